// >>> pkg/page_write_pkg.sv
// Purpose: shared constants for the serial flash page write sequencer
// Assumes: 200 MHz reference clock, link clock sampled as plain input
// Notes:   opcodes, address sizes, buffer shape and timing counts
package page_write_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OPC_PAGE_WRITE_4B = 8'h12;
  localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OPC_QUAD_PAGE_WRITE_4B = 8'h34;
  localparam logic [7:0] OPC_DDR_PAGE_WRITE = 8'hd2;

  // ---------------------------------------------------------------
  // address and array shape
  // ---------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int PAGE_OFF_W = 8;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam int MEM_ADDR_W = 25;
  localparam int PROT_UNIT_W = 16;
  localparam logic [3:0] BITS_SINGLE = 4'h1;
  localparam logic [3:0] BITS_QUAD = 4'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // buffering and timing
  // ---------------------------------------------------------------
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 200;
  localparam int PAGE_WRITE_TIME_NS = 100000;
  localparam int DDR_PAGE_WRITE_TIME_NS = 100000;
  localparam int TIMER_W = 32;

  // sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPC = 7'h02,
    ST_ADDR = 7'h04,
    ST_DATA = 7'h08,
    ST_SKIP = 7'h10,
    ST_FINISH = 7'h20,
    ST_BUSY = 7'h40
  } seq_state_t;

  // least number of clock cycles covering a time in ns, never below one
  function automatic logic [TIMER_W-1:0] ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return TIMER_W'(c);
  endfunction

endpackage

// >>> testbench/host_link.sv
// Purpose: host side of the serial link: clock, select and data lines
// Assumes: mode 0, link clock period 125 ns, still between frames
// Notes:   lines not carrying data show the inverse of their last value
`timescale 1ns/1ps
module host_link (
  // link to the device
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  localparam realtime Q = 31.25;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  // select stays low for the whole command
  task automatic select();
    #(2*Q) o_cs_n = 1'b0;
    #(2*Q);
  endtask
  // release after the last edge; a cut byte is the caller's choice
  task automatic deselect();
    #(2*Q) o_cs_n = 1'b1;
    o_io = ~o_io;
  endtask
  // msb first; m 0 single line, 1 quad, 2 nibble per edge
  task automatic send(input logic [7:0] b, input int n, input int m);
    if (m == 0) begin
      for (int i = 7; i > 7 - n; i--) begin
        o_io = {~o_io[3:1], b[i]};
        #(2*Q) o_sck = 1'b1;
        #(2*Q) o_sck = 1'b0;
      end
    end else if (m == 1) begin
      for (int i = 1; i >= 0; i--) begin
        o_io = b[4*i+:4];
        #(2*Q) o_sck = 1'b1;
        #(2*Q) o_sck = 1'b0;
      end
    end else begin
      o_io = b[7:4];
      #Q o_sck = 1'b1;
      #Q o_io = b[3:0];
      #Q o_sck = 1'b0;
      #Q;
    end
  endtask
endmodule // host_link

// >>> testbench/page_write_props.sv
// Purpose: concurrent checks on the page write sequencer ports
// Assumes: single clock domain, synchronous active-low reset
// Notes:   busy length is counted in helper logic, not by repetition
`timescale 1ns/1ps
module page_write_props
  import page_write_pkg::*;
#(
  parameter int PAGE_WRITE_NS = 100000,
  parameter int DDR_PAGE_WRITE_NS = 100000
) (
  // clock, reset, link select and latch ready
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_latch_ready,
  // watched outputs
  input wire logic o_write_unlock_latch,
  input wire logic o_write_in_progress,
  input wire logic o_latch_valid,
  input wire logic [7:0] o_latch_offset,
  input wire logic [7:0] o_latch_data,
  input wire logic o_latch_discard,
  input wire logic o_prog_start,
  input wire logic o_prog_ddr,
  input wire logic [ADDR_W-1:0] o_prog_addr
);
  localparam int N_PW = (PAGE_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int N_DDR = (DDR_PAGE_WRITE_NS * CLK_MHZ + 999) / 1000;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] busy_cnt;
  logic ddr_run;
  // cycles of the running write; kind latched at launch
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      busy_cnt <= 32'h0;
      ddr_run <= 1'b0;
    end else begin
      busy_cnt <= o_write_in_progress ? busy_cnt + 32'h1 : 32'h0;
      if (o_prog_start) ddr_run <= o_prog_ddr;
    end
  end
  sequence s_launch;
    o_prog_start && o_write_in_progress && !o_write_unlock_latch;
  endsequence
  sequence s_busy_run;
    o_write_in_progress [*8];
  endsequence
  a_start_busy_flags: assert property (o_prog_start |-> s_launch)
    else $error("launch without busy or with latch still set");
  a_busy_holds: assert property (o_prog_start |-> s_busy_run)
    else $error("busy dropped early");
  a_busy_length: assert property ($fell(o_write_in_progress) |->
    busy_cnt == (ddr_run ? N_DDR : N_PW))
    else $error("busy length wrong");
  a_busy_cause: assert property ($rose(o_write_in_progress) |->
    o_prog_start && $past(o_write_unlock_latch))
    else $error("write began without unlock latch");
  a_start_cs_high: assert property (o_prog_start |-> i_cs_n && $past(i_cs_n, 2))
    else $error("write began with select low");
  a_start_when_idle: assert property (o_prog_start |-> !$past(o_write_in_progress))
    else $error("write began while busy");
  a_page_base: assert property (o_prog_start |-> o_prog_addr[7:0] == 8'h00)
    else $error("page base not aligned");
  a_latch_hold: assert property (o_latch_valid && !i_latch_ready |=>
    o_latch_valid && $stable(o_latch_data) && $stable(o_latch_offset))
    else $error("latch byte changed while stalled");
  a_drop_alone: assert property (o_latch_discard |-> !o_prog_start && !o_latch_valid)
    else $error("discard with start or pending byte");
endmodule // page_write_props

bind page_write_seq page_write_props #(
  .PAGE_WRITE_NS(PAGE_WRITE_NS),
  .DDR_PAGE_WRITE_NS(DDR_PAGE_WRITE_NS)
) page_write_props_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
  .i_latch_ready(i_latch_ready), .o_write_unlock_latch(o_write_unlock_latch),
  .o_write_in_progress(o_write_in_progress), .o_latch_valid(o_latch_valid),
  .o_latch_offset(o_latch_offset), .o_latch_data(o_latch_data),
  .o_latch_discard(o_latch_discard), .o_prog_start(o_prog_start),
  .o_prog_ddr(o_prog_ddr), .o_prog_addr(o_prog_addr)
);

// >>> testbench/page_write_seq_tb.sv
// Purpose: self-checking bench for the page write sequencer
// Assumes: host model drives the link; bench plays the page latch
// Notes:   short write times give busy phases of 20 and 28 cycles
`timescale 1ns/1ps
module page_write_seq_tb;
  import page_write_pkg::*;
  logic clk = 0, rst_n = 0, mode4 = 0, qe = 0, ready = 0;
  logic [7:0] ext = 8'h01;
  logic [3:0] lvl = 4'h0;
  logic pcmp = 0, ptb = 0;
  logic sck, cs_n, write_unlock_latch, write_in_progress, lv, disc, pst, pddr, sddr;
  logic [3:0] io;
  logic [7:0] loff, ldat;
  logic [7:0] page [256];
  logic [31:0] paddr, saddr;
  int failures = 0, tests_run = 0, nwr = 0, nst = 0, ndisc = 0;
  always #2.5 clk = ~clk;
  host_link host_link_inst (.o_sck(sck), .o_cs_n(cs_n), .o_io(io));
  page_write_seq #(.PAGE_WRITE_NS(100), .DDR_PAGE_WRITE_NS(140)) page_write_seq_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_io_line(io),
    .i_addr_4byte_mode(mode4), .i_ext_addr(ext), .i_quad_lines_enable(qe),
    .i_protect_complement(pcmp), .i_protect_top_bottom(ptb), .i_protect_level(lvl),
    .o_write_unlock_latch(write_unlock_latch), .o_write_in_progress(write_in_progress), .o_latch_valid(lv),
    .i_latch_ready(ready), .o_latch_offset(loff), .o_latch_data(ldat),
    .o_latch_discard(disc), .o_prog_start(pst), .o_prog_ddr(pddr), .o_prog_addr(paddr));
  // page latch stand-in: ready alternates so the buffer output stalls often
  always @(negedge clk) ready <= ~ready;
  // record latch writes, launches and drops
  always @(posedge clk) begin
    if (rst_n) begin
      if (lv === 1'b1 && ready) begin
        page[loff] = ldat;
        nwr++;
      end
      if (pst === 1'b1) begin
        nst++;
        sddr = pddr;
        saddr = paddr;
      end
      if (disc === 1'b1) ndisc++;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one framed command; tail sends a cut byte of that many bits
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd,
                     input int m, input logic [7:0] v, input int tail);
    host_link_inst.select();
    host_link_inst.send(op, 8, 0);
    for (int i = na - 1; i >= 0; i--) host_link_inst.send(a[8*i+:8], 8, m);
    for (int j = 0; j < nd; j++) host_link_inst.send(v + 8'(j >> 1), 8, m);
    if (tail > 0) host_link_inst.send(8'hc3, tail, 0);
    host_link_inst.deselect();
    // status is looked at on the falling edge, well away from its update
    repeat (60) @(negedge clk);
    for (int k = 0; k < 200 && write_in_progress !== 1'b0; k++) @(negedge clk);
    check("busy_wait", write_in_progress, 32'h0);
  endtask
  task automatic unlock();
    cmd(OPC_WRITE_UNLOCK, 32'h0, 0, 0, 0, 8'h00, 0);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check("latch_rst", write_unlock_latch, 32'h0);
    check("busy_rst", write_in_progress, 32'h0);
    cmd(OPC_PAGE_WRITE, 32'h001234fe, 3, 3, 0, 8'ha0, 0);
    check("start_cnt", nst, 32'h0);
    check("write_cnt", nwr, 32'h0);
    unlock();
    check("latch_set", write_unlock_latch, 32'h1);
    cmd(OPC_PAGE_WRITE, 32'h001234fe, 3, 3, 0, 8'ha0, 0);
    check("start_cnt", nst, 32'h1);
    check("page_addr", saddr, 32'h01123400);
    check("off_ff", page[8'hff], 32'ha0);
    check("off_00", page[8'h00], 32'ha1);
    check("write_cnt", nwr, 32'h3);
    check("latch_clr", write_unlock_latch, 32'h0);
    check("busy_end", write_in_progress, 32'h0);
    unlock();
    cmd(OPC_PAGE_WRITE, 32'h00000010, 3, 1, 0, 8'h11, 3);
    check("drop_cnt", ndisc, 32'h1);
    check("start_cnt", nst, 32'h1);
    check("latch_keep", write_unlock_latch, 32'h1);
    cmd(OPC_PAGE_WRITE_4B, 32'h00abcd10, 4, 1, 0, 8'h22, 0);
    check("addr_4b", saddr, 32'h00abcd00);
    unlock();
    @(negedge clk) lvl = 4'ha;
    cmd(OPC_PAGE_WRITE, 32'h00000020, 3, 1, 0, 8'h33, 0);
    check("start_cnt", nst, 32'h2);
    @(negedge clk) lvl = 4'h0;
    mode4 = 1'b1;
    cmd(OPC_QUAD_PAGE_WRITE, 32'h00010040, 4, 1, 1, 8'h44, 0);
    check("start_cnt", nst, 32'h2);
    @(negedge clk) qe = 1'b1;
    cmd(OPC_QUAD_PAGE_WRITE, 32'h00010040, 4, 2, 1, 8'h44, 0);
    check("start_cnt", nst, 32'h3);
    check("quad_addr", saddr, 32'h00010000);
    check("off_40", page[8'h40], 32'h44);
    @(negedge clk) mode4 = 1'b0;
    unlock();
    cmd(OPC_QUAD_PAGE_WRITE_4B, 32'h00020000, 4, 257, 1, 8'h00, 0);
    check("addr_34", saddr, 32'h00020000);
    check("last_kept", page[8'h00], 32'h80);
    check("end_byte", page[8'hff], 32'h7f);
    unlock();
    cmd(OPC_DDR_PAGE_WRITE, 32'h00003050, 3, 1, 2, 8'h5a, 0);
    check("ddr_flag", sddr, 32'h1);
    check("addr_ddr", saddr, 32'h01003000);
    check("off_50", page[8'h50], 32'h5a);
    // complement of a bottom 64 KB region: only the lowest block stays open
    unlock();
    @(negedge clk) pcmp = 1'b1;
    ptb = 1'b1;
    lvl = 4'h1;
    cmd(OPC_DDR_PAGE_WRITE, 32'h00000020, 3, 1, 2, 8'h77, 0);
    check("start_cnt", nst, 32'h5);
    cmd(OPC_PAGE_WRITE_4B, 32'h00000020, 4, 1, 0, 8'h66, 0);
    check("start_cnt", nst, 32'h6);
    check("addr_low", saddr, 32'h00000000);
    check("off_20", page[8'h20], 32'h66);
    check("ddr_flag", sddr, 32'h0);
    print_verdict();
  end
  // watchdog: the whole sequence needs well under 300 us
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
endmodule // page_write_seq_tb

// >>> verilog/page_byte_fifo.sv
// Purpose: small first-in first-out buffer for page bytes with offset
// Assumes: single clock, synchronous active-low reset
// Notes:   read data come out of a register; empty covers that register
`timescale 1ns/1ps
module page_byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  // nothing stored anywhere
  output logic o_empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic load;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign o_in_ready = (r.cnt != (PW+1)'(DEPTH));
  assign push = i_in_valid && o_in_ready;
  // output register refills when empty or being taken this cycle
  assign load = (r.cnt != '0) && (!r.ov || i_out_ready);
  assign o_out_valid = r.ov;
  assign o_out_data = r.od;
  assign o_empty = !r.ov && (r.cnt == '0);

  // pointer and count update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.wp = (r.wp == PW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
    end
    if (load) begin
      next_r.rp = (r.rp == PW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
      next_r.od = mem[r.rp];
      next_r.ov = 1'b1;
    end else if (i_out_ready) begin
      next_r.ov = 1'b0;
    end
    next_r.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(load);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // storage has no reset, only valid entries are ever read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[r.wp] <= i_in_data;
    end
  end

endmodule // page_byte_fifo

// >>> verilog/page_write_seq.sv
// Purpose: receives page write commands on the serial link and runs
//          the self-timed write cycle
// Assumes: link clock and select are sampled by i_ref_clk, link clock
//          well below a quarter of the reference rate
// Notes:   bytes go to an external page latch that holds unchanged
//          data for untouched offsets; commit or discard at frame end
//
// Notes on behaviour
// - program opcode only after write unlock command
// - unlock opcode decoded sets write unlock latch
// - data past page end wraps to page start
// - over 256 bytes: last 256 kept
// - under 256 bytes: other page bytes unchanged
// - select rises on byte boundary, else dropped
// - write cycle starts when select rises
// - write in progress shown during cycle only
// - unlock latch cleared before cycle ends
// - protected page commands are not executed
// - opcode 12h always takes four address bytes
// - quad opcode needs quad lines enable
// - quad commands need unlock latch set
// - quad commands otherwise match single line
// - ddr: opcode serial, then nibble per edge
// - ddr write uses its own cycle time
// - ddr dropped on partial byte or protection
`timescale 1ns/1ps
module page_write_seq
  import page_write_pkg::*;
#(
  parameter int PAGE_WRITE_NS = PAGE_WRITE_TIME_NS,
  parameter int DDR_PAGE_WRITE_NS = DDR_PAGE_WRITE_TIME_NS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // serial link from the host
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io_line,
  // configuration and protection bits
  input wire logic i_addr_4byte_mode,
  input wire logic [7:0] i_ext_addr,
  input wire logic i_quad_lines_enable,
  input wire logic i_protect_complement,
  input wire logic i_protect_top_bottom,
  input wire logic [3:0] i_protect_level,
  // status
  output logic o_write_unlock_latch,
  output logic o_write_in_progress,
  // page latch port
  output logic o_latch_valid,
  input wire logic i_latch_ready,
  output logic [7:0] o_latch_offset,
  output logic [7:0] o_latch_data,
  output logic o_latch_discard,
  // array write cycle control
  output logic o_prog_start,
  output logic o_prog_ddr,
  output logic [ADDR_W-1:0] o_prog_addr
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic [7:0] sh;
    logic [3:0] nbits;
    logic [2:0] abytes;
    logic a4;
    logic [ADDR_W-1:0] addr;
    logic [7:0] off;
    logic quad;
    logic ddr;
    logic ddr_live;
    logic any_data;
    logic overrun;
    logic accept;
    logic write_unlock_latch;
    logic write_in_progress;
    logic [TIMER_W-1:0] timer;
    logic prog_start;
    logic discard;
  } seq_t;

  localparam seq_t SEQ_RESET = '{
    st: ST_IDLE, sck_m: 1'b0, sck_s: 1'b0, sck_d: 1'b0,
    cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, io_m: 4'h0, io_s: 4'h0,
    sh: 8'h00, nbits: 4'h0, abytes: 3'h0, a4: 1'b0, addr: '0, off: 8'h00,
    quad: 1'b0, ddr: 1'b0, ddr_live: 1'b0, any_data: 1'b0,
    overrun: 1'b0, accept: 1'b0, write_unlock_latch: 1'b0, write_in_progress: 1'b0, timer: '0,
    prog_start: 1'b0, discard: 1'b0
  };

  localparam logic [TIMER_W-1:0] PAGE_WRITE_CYC = ns_to_cycles(PAGE_WRITE_NS);
  localparam logic [TIMER_W-1:0] DDR_PAGE_WRITE_CYC = ns_to_cycles(DDR_PAGE_WRITE_NS);

  seq_t r;
  seq_t next_r;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_empty;
  logic [FIFO_WIDTH-1:0] fifo_out;

  // ---------------------------------------------------------------
  // protection decode
  // ---------------------------------------------------------------
  // level 0 protects nothing; each level doubles a 64 KB region from
  // the top or bottom, complement swaps protected and open parts
  function automatic logic is_protected(input logic [ADDR_W-1:0] a,
                                        input logic cmp, input logic tb,
                                        input logic [3:0] lvl);
    logic [MEM_ADDR_W-1:0] ma;
    logic [MEM_ADDR_W:0] size;
    logic hit;
    ma = a[MEM_ADDR_W-1:0];
    size = '0;
    hit = 1'b0;
    if (lvl == 4'h0) begin
      hit = 1'b0;
    end else if (32'(lvl) - 1 >= MEM_ADDR_W - PROT_UNIT_W) begin
      hit = 1'b1;
    end else begin
      size = (MEM_ADDR_W+1)'(1) << (32'(lvl) - 1 + PROT_UNIT_W);
      if (tb) begin
        hit = ({1'b0, ma} < size);
      end else begin
        hit = ({1'b0, ma} >= ((MEM_ADDR_W+1)'(1) << MEM_ADDR_W) - size);
      end
    end
    return hit ^ cmp;
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic take;
    logic wide;
    logic [7:0] nsh;
    logic [3:0] nb;
    logic done;
    logic [ADDR_W-1:0] fa;
    rise = 1'b0;
    fall = 1'b0;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    take = 1'b0;
    wide = 1'b0;
    nsh = 8'h00;
    nb = 4'h0;
    done = 1'b0;
    fa = '0;
    next_r = r;
    fifo_push = 1'b0;
    // two-stage sampling of every link input
    next_r.sck_m = i_sck;
    next_r.sck_s = r.sck_m;
    next_r.sck_d = r.sck_s;
    next_r.cs_m = i_cs_n;
    next_r.cs_s = r.cs_m;
    next_r.cs_d = r.cs_s;
    next_r.io_m = i_io_line;
    next_r.io_s = r.io_m;
    next_r.prog_start = 1'b0;
    next_r.discard = 1'b0;
    rise = r.sck_s && !r.sck_d && !r.cs_s;
    fall = !r.sck_s && r.sck_d && !r.cs_s;
    cs_rise = r.cs_s && !r.cs_d;
    cs_fall = !r.cs_s && r.cs_d;
    // ddr samples both edges once the first address edge has come
    take = rise || (fall && r.ddr && r.ddr_live);
    wide = (r.quad || r.ddr) && (r.st != ST_OPC);
    nsh = wide ? {r.sh[3:0], r.io_s} : {r.sh[6:0], r.io_s[0]};
    nb = r.nbits + (wide ? BITS_QUAD : BITS_SINGLE);
    done = take && (nb == BITS_BYTE);
    if (take) begin
      next_r.sh = nsh;
      next_r.nbits = done ? 4'h0 : nb;
      if (r.ddr && rise) begin
        next_r.ddr_live = 1'b1;
      end
    end
    unique case (r.st)
      ST_IDLE: begin
        if (cs_fall) begin
          next_r.st = ST_OPC;
          next_r.nbits = 4'h0;
          next_r.quad = 1'b0;
          next_r.ddr = 1'b0;
          next_r.ddr_live = 1'b0;
          next_r.any_data = 1'b0;
          next_r.overrun = 1'b0;
          next_r.addr = '0;
        end
      end
      ST_OPC: begin
        if (cs_rise) begin
          next_r.st = ST_IDLE;
        end else if (done) begin
          next_r.st = ST_SKIP;
          next_r.a4 = i_addr_4byte_mode;
          unique case (nsh)
            OPC_WRITE_UNLOCK: begin
              next_r.write_unlock_latch = 1'b1;
            end
            OPC_PAGE_WRITE, OPC_PAGE_WRITE_4B: begin
              next_r.st = r.write_unlock_latch ? ST_ADDR : ST_SKIP;
              next_r.a4 = (nsh == OPC_PAGE_WRITE_4B) || i_addr_4byte_mode;
            end
            OPC_QUAD_PAGE_WRITE, OPC_QUAD_PAGE_WRITE_4B: begin
              // quad needs both the latch and the quad line enable
              next_r.st = (r.write_unlock_latch && i_quad_lines_enable) ? ST_ADDR : ST_SKIP;
              next_r.quad = 1'b1;
              next_r.a4 = (nsh == OPC_QUAD_PAGE_WRITE_4B) || i_addr_4byte_mode;
            end
            OPC_DDR_PAGE_WRITE: begin
              next_r.st = (r.write_unlock_latch && i_quad_lines_enable) ? ST_ADDR : ST_SKIP;
              next_r.ddr = 1'b1;
            end
            default: begin
              next_r.st = ST_SKIP;
            end
          endcase
          next_r.abytes = next_r.a4 ? ADDR_BYTES_4 : ADDR_BYTES_3;
        end
      end
      ST_ADDR: begin
        if (cs_rise) begin
          next_r.st = ST_IDLE;
        end else if (done) begin
          next_r.addr = {r.addr[ADDR_W-9:0], nsh};
          next_r.abytes = r.abytes - 3'h1;
          if (r.abytes == 3'h1) begin
            // 3-byte mode takes its top byte from the extended register
            fa = r.a4 ? {r.addr[ADDR_W-9:0], nsh} : {i_ext_addr, r.addr[15:0], nsh};
            next_r.addr = fa;
            next_r.off = nsh;
            next_r.st = ST_DATA;
            if (is_protected(fa, i_protect_complement, i_protect_top_bottom,
                             i_protect_level)) begin
              next_r.st = ST_SKIP;
            end
          end
        end
      end
      ST_DATA: begin
        if (cs_rise) begin
          // partial last byte, no data or lost bytes drop the command
          next_r.accept = (r.nbits == 4'h0) && r.any_data && !r.overrun;
          next_r.st = ST_FINISH;
        end else if (done) begin
          fifo_push = 1'b1;
          if (fifo_in_ready) begin
            next_r.off = r.off + 8'h01;
            next_r.any_data = 1'b1;
          end else begin
            next_r.overrun = 1'b1;
          end
        end
      end
      ST_SKIP: begin
        if (cs_rise) begin
          next_r.st = ST_IDLE;
        end
      end
      ST_FINISH: begin
        // the latch must hold every byte before commit or discard
        if (fifo_empty) begin
          next_r.st = r.cs_s ? ST_IDLE : ST_SKIP;
          if (r.accept) begin
            next_r.st = ST_BUSY;
            next_r.write_in_progress = 1'b1;
            next_r.write_unlock_latch = 1'b0;
            next_r.prog_start = 1'b1;
            next_r.timer = r.ddr ? DDR_PAGE_WRITE_CYC : PAGE_WRITE_CYC;
          end else begin
            next_r.discard = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        // frames during the cycle are ignored, status stays readable
        next_r.timer = r.timer - TIMER_W'(1);
        if (r.timer == TIMER_W'(1)) begin
          next_r.write_in_progress = 1'b0;
          next_r.st = r.cs_s ? ST_IDLE : ST_SKIP;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      r <= SEQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // byte buffer toward the page latch
  // ---------------------------------------------------------------
  // the link cannot be stalled, so a full buffer marks the frame lost
  page_byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data({r.off, next_r.sh}),
    .o_out_valid(o_latch_valid),
    .i_out_ready(i_latch_ready),
    .o_out_data(fifo_out),
    .o_empty(fifo_empty)
  );

  // outputs
  assign o_latch_offset = fifo_out[15:8];
  assign o_latch_data = fifo_out[7:0];
  assign o_write_unlock_latch = r.write_unlock_latch;
  assign o_write_in_progress = r.write_in_progress;
  assign o_prog_start = r.prog_start;
  assign o_latch_discard = r.discard;
  assign o_prog_ddr = r.ddr;
  assign o_prog_addr = {r.addr[ADDR_W-1:PAGE_OFF_W], 8'h00};

endmodule // page_write_seq
